// File: logic/cmpc_defs.svh
// Constants for the comparator control register bank: addresses, field
// positions, reset values and synchroniser depth.
// Assumes inclusion by the comparator control modules and the testbench.
//
// Operation
// - Bit 7 of the control register switches the comparator on when 1 and off when 0.
// - Bit 6 of the control register reads 1 when the comparator is on and the positive input is above the negative.
// - A rising comparator transition sets the rising-edge flag until software writes it to 0.
// - A falling comparator transition sets the falling-edge flag until software writes it to 0.
// - Bits 3-2 of the control register pick positive hysteresis off, 5, 10 or 20 mV.
// - Bits 1-0 of the control register pick negative hysteresis off, 5, 10 or 20 mV.
// - The upper mux nibble picks the negative pin, and a set top bit picks no pin.
// - The lower mux nibble picks the positive pin, and a set top bit picks no pin.
// - A rising edge requests an interrupt only while the rising interrupt enable is 1.
// - A falling edge requests an interrupt only while the falling interrupt enable is 1.
// - Bits 1-0 of the mode register pick response mode 0 to 3 and reset to mode 2.
// - Unused bit pairs of the mode register read as 00 and ignore writes.
// - While the comparator is off, its output towards the port pin is held low.

`ifndef CMPC_DEFS_SVH
`define CMPC_DEFS_SVH

//----------------------------------------------------------------------
// Register addresses
//----------------------------------------------------------------------
`define CMPC_ADDR_CTRL      8'h9b
`define CMPC_ADDR_MODE      8'h9d
`define CMPC_ADDR_MUX       8'h9f

//----------------------------------------------------------------------
// Field positions
//----------------------------------------------------------------------
`define CMPC_CTRL_EN_BIT    7
`define CMPC_CTRL_OUT_BIT   6
`define CMPC_CTRL_RISE_BIT  5
`define CMPC_CTRL_FALL_BIT  4
`define CMPC_CTRL_PHYS_LSB  2
`define CMPC_CTRL_NHYS_LSB  0
`define CMPC_MODE_RIE_BIT   5
`define CMPC_MODE_FIE_BIT   4
`define CMPC_MODE_MD_LSB    0
`define CMPC_MUX_NEG_LSB    4
`define CMPC_MUX_POS_LSB    0

//----------------------------------------------------------------------
// Reset values and timing
//----------------------------------------------------------------------
`define CMPC_RST_CTRL       8'h00
`define CMPC_RST_MUX        8'hff
`define CMPC_RST_MODE       8'h02
`define CMPC_SYNC_STAGES    2

`endif

// File: logic/cmpc_pkg.sv
// Types shared by the comparator control modules.
// Assumes nothing of its surroundings.

package cmpc_pkg;

	//------------------------------------------------------------------
	// Hysteresis settings
	//------------------------------------------------------------------
	typedef enum logic [1:0] {
		CMPC_HYST_OFF  = 2'b00,
		CMPC_HYST_5MV  = 2'b01,
		CMPC_HYST_10MV = 2'b10,
		CMPC_HYST_20MV = 2'b11
	} cmpc_hyst_t;

	//------------------------------------------------------------------
	// Response time modes, fastest first
	//------------------------------------------------------------------
	typedef enum logic [1:0] {
		CMPC_MODE_0 = 2'b00,
		CMPC_MODE_1 = 2'b01,
		CMPC_MODE_2 = 2'b10,
		CMPC_MODE_3 = 2'b11
	} cmpc_resp_mode_t;

endpackage

// File: logic/cmpc_edge_detect.sv
// Synchroniser and edge detector for the raw comparator output.
// Assumes an asynchronous level input and one system clock.
`timescale 1ns/1ps
`include "cmpc_defs.svh"

module cmpc_edge_detect #(
	parameter int STAGES = `CMPC_SYNC_STAGES
) (
	// Clock and reset
	input  wire logic clk_in,
	input  wire logic rst_n_in,
	// Comparator side
	input  wire logic async_in,
	input  wire logic enable_in,
	// Results
	output logic      level_out,
	output logic      rise_out,
	output logic      fall_out
);

	logic [STAGES-1:0] sync_ff;
	logic [STAGES-1:0] nxt_sync;
	logic              prev_ff;
	logic              nxt_prev;

	// Shift chain; only the last stage is looked at
	always_comb
	begin
		nxt_sync = {sync_ff[STAGES-2:0], async_in};
		nxt_prev = sync_ff[STAGES-1];
	end

	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			sync_ff <= '0;
			prev_ff <= 1'b0;
		end
		else
		begin
			sync_ff <= nxt_sync;
			prev_ff <= nxt_prev;
		end
	end

	// Edges from consecutive samples, gated by enable
	assign level_out = sync_ff[STAGES-1];
	assign rise_out  = enable_in && sync_ff[STAGES-1] && !prev_ff;
	assign fall_out  = enable_in && !sync_ff[STAGES-1] && prev_ff;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	a_edge_needs_enable: assert property (!enable_in |-> !rise_out && !fall_out)
		else $error("edge reported while comparator disabled");
	a_rise_after_low: assert property (rise_out |-> $past(level_out) == 1'b0)
		else $error("rise without a low sample before it");

endmodule // cmpc_edge_detect

// File: logic/cmpc_regs.sv
// Comparator control register bank: control, mux select and mode
// registers on the special function register port, edge flags and
// masked edge interrupt requests.
// Assumes a raw comparator output from the analog block, asynchronous
// to REF_CLK_IN, and a core that reads and writes one register a cycle.
`timescale 1ns/1ps
`include "cmpc_defs.svh"

module cmpc_regs
	import cmpc_pkg::*;
#(
	parameter int PIN_COUNT = 8
) (
	// Clock and reset
	input  wire logic                 REF_CLK_IN,
	input  wire logic                 RST_N_IN,
	// Special function register port
	input  wire logic [7:0]           SFR_ADDR_IN,
	input  wire logic                 SFR_WR_IN,
	input  wire logic                 SFR_RD_IN,
	input  wire logic [7:0]           SFR_WDATA_IN,
	output logic      [7:0]           SFR_RDATA_OUT,
	// Analog comparator
	input  wire logic                 CMP_RAW_IN,
	output logic                      CMP_ENABLE_OUT,
	output cmpc_hyst_t                POS_HYST_SEL_OUT,
	output cmpc_hyst_t                NEG_HYST_SEL_OUT,
	output cmpc_resp_mode_t           RESPONSE_MODE_SEL_OUT,
	output logic      [PIN_COUNT-1:0] POS_PIN_SEL_OUT,
	output logic      [PIN_COUNT-1:0] NEG_PIN_SEL_OUT,
	// Port pin and interrupt requests
	output logic                      CMP_PIN_OUT,
	output logic                      RISE_IRQ_OUT,
	output logic                      FALL_IRQ_OUT
);

	//------------------------------------------------------------------
	// Declarations
	//------------------------------------------------------------------
	logic                 cmp_enable_ff;
	logic                 nxt_cmp_enable;
	logic                 rise_flag_ff;
	logic                 nxt_rise_flag;
	logic                 fall_flag_ff;
	logic                 nxt_fall_flag;
	cmpc_hyst_t           pos_hyst_sel_ff;
	cmpc_hyst_t           nxt_pos_hyst_sel;
	cmpc_hyst_t           neg_hyst_sel_ff;
	cmpc_hyst_t           nxt_neg_hyst_sel;
	logic [7:0]           input_mux_ff;
	logic [7:0]           nxt_input_mux;
	logic                 rise_irq_en_ff;
	logic                 nxt_rise_irq_en;
	logic                 fall_irq_en_ff;
	logic                 nxt_fall_irq_en;
	cmpc_resp_mode_t      response_mode_sel_ff;
	cmpc_resp_mode_t      nxt_response_mode_sel;
	logic [7:0]           rdata_ff;
	logic [7:0]           nxt_rdata;
	logic                 pin_ff;
	logic                 nxt_pin;
	logic                 rise_irq_ff;
	logic                 nxt_rise_irq;
	logic                 fall_irq_ff;
	logic                 nxt_fall_irq;
	logic [PIN_COUNT-1:0] pos_pin_sel_ff;
	logic [PIN_COUNT-1:0] neg_pin_sel_ff;
	logic [PIN_COUNT-1:0] pos_pin_dec;
	logic [PIN_COUNT-1:0] neg_pin_dec;
	logic                 cmp_level;
	logic                 cmp_output_state;
	logic                 rise_pulse;
	logic                 fall_pulse;
	logic                 ctrl_wr;
	logic                 mode_wr;
	logic                 mux_wr;
	logic [3:0]           pos_input_sel;
	logic [3:0]           neg_input_sel;

	//------------------------------------------------------------------
	// Comparator output synchroniser and edge detector
	//------------------------------------------------------------------
	cmpc_edge_detect #(
		.STAGES    (`CMPC_SYNC_STAGES)
	) u_edge (
		.clk_in    (REF_CLK_IN),
		.rst_n_in  (RST_N_IN),
		.async_in  (CMP_RAW_IN),
		.enable_in (cmp_enable_ff),
		.level_out (cmp_level),
		.rise_out  (rise_pulse),
		.fall_out  (fall_pulse)
	);

	// Status reads low while the comparator is off
	assign cmp_output_state = cmp_enable_ff && cmp_level;

	//------------------------------------------------------------------
	// Address decode
	//------------------------------------------------------------------
	assign ctrl_wr = SFR_WR_IN && (SFR_ADDR_IN == `CMPC_ADDR_CTRL);
	assign mode_wr = SFR_WR_IN && (SFR_ADDR_IN == `CMPC_ADDR_MODE);
	assign mux_wr  = SFR_WR_IN && (SFR_ADDR_IN == `CMPC_ADDR_MUX);

	//------------------------------------------------------------------
	// Control register
	//------------------------------------------------------------------
	// Next values; an edge beats a software clear in the same cycle
	always_comb
	begin
		nxt_cmp_enable   = cmp_enable_ff;
		nxt_rise_flag    = rise_flag_ff;
		nxt_fall_flag    = fall_flag_ff;
		nxt_pos_hyst_sel = pos_hyst_sel_ff;
		nxt_neg_hyst_sel = neg_hyst_sel_ff;
		if (ctrl_wr)
		begin
			nxt_cmp_enable   = SFR_WDATA_IN[`CMPC_CTRL_EN_BIT];
			nxt_rise_flag    = SFR_WDATA_IN[`CMPC_CTRL_RISE_BIT];
			nxt_fall_flag    = SFR_WDATA_IN[`CMPC_CTRL_FALL_BIT];
			nxt_pos_hyst_sel = cmpc_hyst_t'(SFR_WDATA_IN[`CMPC_CTRL_PHYS_LSB +: 2]);
			nxt_neg_hyst_sel = cmpc_hyst_t'(SFR_WDATA_IN[`CMPC_CTRL_NHYS_LSB +: 2]);
		end
		if (rise_pulse)
			nxt_rise_flag = 1'b1;
		if (fall_pulse)
			nxt_fall_flag = 1'b1;
	end

	always_ff @(posedge REF_CLK_IN)
	begin
		if (!RST_N_IN)
		begin
			cmp_enable_ff   <= 1'(`CMPC_RST_CTRL >> `CMPC_CTRL_EN_BIT);
			rise_flag_ff    <= 1'b0;
			fall_flag_ff    <= 1'b0;
			pos_hyst_sel_ff <= CMPC_HYST_OFF;
			neg_hyst_sel_ff <= CMPC_HYST_OFF;
		end
		else
		begin
			cmp_enable_ff   <= nxt_cmp_enable;
			rise_flag_ff    <= nxt_rise_flag;
			fall_flag_ff    <= nxt_fall_flag;
			pos_hyst_sel_ff <= nxt_pos_hyst_sel;
			neg_hyst_sel_ff <= nxt_neg_hyst_sel;
		end
	end

	//------------------------------------------------------------------
	// Input mux and mode registers
	//------------------------------------------------------------------
	// Unused mode bits are simply not stored
	always_comb
	begin
		nxt_input_mux         = input_mux_ff;
		nxt_rise_irq_en       = rise_irq_en_ff;
		nxt_fall_irq_en       = fall_irq_en_ff;
		nxt_response_mode_sel = response_mode_sel_ff;
		if (mux_wr)
			nxt_input_mux = SFR_WDATA_IN;
		if (mode_wr)
		begin
			nxt_rise_irq_en       = SFR_WDATA_IN[`CMPC_MODE_RIE_BIT];
			nxt_fall_irq_en       = SFR_WDATA_IN[`CMPC_MODE_FIE_BIT];
			nxt_response_mode_sel = cmpc_resp_mode_t'(SFR_WDATA_IN[`CMPC_MODE_MD_LSB +: 2]);
		end
	end

	always_ff @(posedge REF_CLK_IN)
	begin
		if (!RST_N_IN)
		begin
			input_mux_ff         <= `CMPC_RST_MUX;
			rise_irq_en_ff       <= 1'b0;
			fall_irq_en_ff       <= 1'b0;
			response_mode_sel_ff <= CMPC_MODE_2;
		end
		else
		begin
			input_mux_ff         <= nxt_input_mux;
			rise_irq_en_ff       <= nxt_rise_irq_en;
			fall_irq_en_ff       <= nxt_fall_irq_en;
			response_mode_sel_ff <= nxt_response_mode_sel;
		end
	end

	//------------------------------------------------------------------
	// Pin select decode
	//------------------------------------------------------------------
	assign pos_input_sel = input_mux_ff[`CMPC_MUX_POS_LSB +: 4];
	assign neg_input_sel = input_mux_ff[`CMPC_MUX_NEG_LSB +: 4];

	// One-hot pin select; a set top bit leaves every pin off
	generate
		for (genvar i = 0; i < PIN_COUNT; i++)
		begin : g_pin_dec
			assign pos_pin_dec[i] = !pos_input_sel[3] && (pos_input_sel[2:0] == 3'(i));
			assign neg_pin_dec[i] = !neg_input_sel[3] && (neg_input_sel[2:0] == 3'(i));
		end
	endgenerate

	//------------------------------------------------------------------
	// Read data, pin output and interrupt requests
	//------------------------------------------------------------------
	// Read mux; unmapped addresses read zero
	always_comb
	begin
		nxt_rdata = 8'h00;
		if (SFR_RD_IN)
		begin
			unique case (SFR_ADDR_IN)
				`CMPC_ADDR_CTRL: nxt_rdata = {cmp_enable_ff, cmp_output_state,
					rise_flag_ff, fall_flag_ff, pos_hyst_sel_ff, neg_hyst_sel_ff};
				`CMPC_ADDR_MODE: nxt_rdata = {2'b00, rise_irq_en_ff, fall_irq_en_ff,
					2'b00, response_mode_sel_ff};
				`CMPC_ADDR_MUX:  nxt_rdata = input_mux_ff;
				default:         nxt_rdata = 8'h00;
			endcase
		end
		nxt_pin      = cmp_enable_ff && cmp_level;
		nxt_rise_irq = rise_flag_ff && rise_irq_en_ff;
		nxt_fall_irq = fall_flag_ff && fall_irq_en_ff;
	end

	always_ff @(posedge REF_CLK_IN)
	begin
		if (!RST_N_IN)
		begin
			rdata_ff       <= 8'h00;
			pin_ff         <= 1'b0;
			rise_irq_ff    <= 1'b0;
			fall_irq_ff    <= 1'b0;
			pos_pin_sel_ff <= '0;
			neg_pin_sel_ff <= '0;
		end
		else
		begin
			rdata_ff       <= nxt_rdata;
			pin_ff         <= nxt_pin;
			rise_irq_ff    <= nxt_rise_irq;
			fall_irq_ff    <= nxt_fall_irq;
			pos_pin_sel_ff <= pos_pin_dec;
			neg_pin_sel_ff <= neg_pin_dec;
		end
	end

	// Outputs straight from flip-flops
	assign SFR_RDATA_OUT         = rdata_ff;
	assign CMP_ENABLE_OUT        = cmp_enable_ff;
	assign POS_HYST_SEL_OUT      = pos_hyst_sel_ff;
	assign NEG_HYST_SEL_OUT      = neg_hyst_sel_ff;
	assign RESPONSE_MODE_SEL_OUT = response_mode_sel_ff;
	assign POS_PIN_SEL_OUT       = pos_pin_sel_ff;
	assign NEG_PIN_SEL_OUT       = neg_pin_sel_ff;
	assign CMP_PIN_OUT           = pin_ff;
	assign RISE_IRQ_OUT          = rise_irq_ff;
	assign FALL_IRQ_OUT          = fall_irq_ff;

	//------------------------------------------------------------------
	// Assertions
	//------------------------------------------------------------------
	default clocking cb @(posedge REF_CLK_IN); endclocking

	sequence s_ctrl_write;
		SFR_WR_IN && SFR_ADDR_IN == `CMPC_ADDR_CTRL;
	endsequence

	sequence s_rise_clear;
		s_ctrl_write ##0 !SFR_WDATA_IN[`CMPC_CTRL_RISE_BIT];
	endsequence

	sequence s_fall_clear;
		s_ctrl_write ##0 !SFR_WDATA_IN[`CMPC_CTRL_FALL_BIT];
	endsequence

	a_enable_write: assert property (disable iff (!RST_N_IN)
		s_ctrl_write |=> CMP_ENABLE_OUT == $past(SFR_WDATA_IN[7]))
		else $error("enable bit did not follow the write");

	a_status_read: assert property (disable iff (!RST_N_IN)
		SFR_RD_IN && SFR_ADDR_IN == `CMPC_ADDR_CTRL
		|=> SFR_RDATA_OUT[6] == $past(cmp_output_state))
		else $error("status bit read back wrong");

	a_rise_flag_set: assert property (disable iff (!RST_N_IN)
		rise_pulse |=> rise_flag_ff)
		else $error("rising edge lost");

	a_rise_flag_hold: assert property (disable iff (!RST_N_IN)
		rise_flag_ff && !(ctrl_wr && !SFR_WDATA_IN[`CMPC_CTRL_RISE_BIT]) |=> rise_flag_ff)
		else $error("rising flag dropped without a clear");

	a_rise_flag_clear: assert property (disable iff (!RST_N_IN)
		s_rise_clear ##0 !rise_pulse |=> !rise_flag_ff)
		else $error("rising flag not cleared by software");

	a_fall_flag_set: assert property (disable iff (!RST_N_IN)
		fall_pulse |=> fall_flag_ff)
		else $error("falling edge lost");

	a_fall_flag_hold: assert property (disable iff (!RST_N_IN)
		fall_flag_ff && !(ctrl_wr && !SFR_WDATA_IN[`CMPC_CTRL_FALL_BIT]) |=> fall_flag_ff)
		else $error("falling flag dropped without a clear");

	a_fall_flag_clear: assert property (disable iff (!RST_N_IN)
		s_fall_clear ##0 !fall_pulse |=> !fall_flag_ff)
		else $error("falling flag not cleared by software");

	a_mux_none_sel: assert property (disable iff (!RST_N_IN)
		input_mux_ff[3] |=> POS_PIN_SEL_OUT == '0)
		else $error("positive pin selected for a none code");

	a_mux_neg_sel: assert property (disable iff (!RST_N_IN)
		!input_mux_ff[7] |=> $onehot(NEG_PIN_SEL_OUT))
		else $error("negative pin select not one-hot");

	a_rise_irq_gate: assert property (disable iff (!RST_N_IN)
		RISE_IRQ_OUT |-> $past(rise_irq_en_ff) && $past(rise_flag_ff))
		else $error("rising interrupt without enable");

	a_fall_irq_gate: assert property (disable iff (!RST_N_IN)
		FALL_IRQ_OUT |-> $past(fall_irq_en_ff) && $past(fall_flag_ff))
		else $error("falling interrupt without enable");

	a_mode_unused_zero: assert property (disable iff (!RST_N_IN)
		SFR_RD_IN && SFR_ADDR_IN == `CMPC_ADDR_MODE
		|=> SFR_RDATA_OUT[7:6] == 2'b00 && SFR_RDATA_OUT[3:2] == 2'b00)
		else $error("unused mode bits read nonzero");

	a_pin_low_off: assert property (disable iff (!RST_N_IN)
		!cmp_enable_ff ##1 !cmp_enable_ff |-> !CMP_PIN_OUT)
		else $error("pin output high while disabled");

	a_reset_values: assert property (!RST_N_IN |=>
		CMP_ENABLE_OUT == 1'b0 && input_mux_ff == 8'hff
		&& RESPONSE_MODE_SEL_OUT == CMPC_MODE_2 && !rise_flag_ff)
		else $error("register reset value wrong");

endmodule // cmpc_regs

// File: verif/tb.sv
// Self-checking testbench for the comparator control register bank.
// Assumes the design files under logic/ are compiled first and a 40 MHz clock.
`timescale 1ns/1ps
`include "cmpc_defs.svh"

module tb;

	//------------------------------------------------------------------
	// Signals
	//------------------------------------------------------------------
	logic       ref_clk;
	logic       rst_n;
	logic [7:0] sfr_addr;
	logic       sfr_wr;
	logic       sfr_rd;
	logic [7:0] sfr_wdata;
	logic [7:0] rdata;
	logic       cmp_raw;
	logic       cmp_en;
	logic [1:0] phys;
	logic [1:0] nhys;
	logic [1:0] rmode;
	logic [7:0] psel;
	logic [7:0] nsel;
	logic       pin;
	logic       rirq;
	logic       firq;
	int         err_count;
	int         n_checks;
	int         cycles = 0;
	logic [3:0] p;
	logic [3:0] n;
	logic [1:0] c;

	//------------------------------------------------------------------
	// Design under test
	//------------------------------------------------------------------
	cmpc_regs uut (
		.REF_CLK_IN            (ref_clk),
		.RST_N_IN              (rst_n),
		.SFR_ADDR_IN           (sfr_addr),
		.SFR_WR_IN             (sfr_wr),
		.SFR_RD_IN             (sfr_rd),
		.SFR_WDATA_IN          (sfr_wdata),
		.SFR_RDATA_OUT         (rdata),
		.CMP_RAW_IN            (cmp_raw),
		.CMP_ENABLE_OUT        (cmp_en),
		.POS_HYST_SEL_OUT      (phys),
		.NEG_HYST_SEL_OUT      (nhys),
		.RESPONSE_MODE_SEL_OUT (rmode),
		.POS_PIN_SEL_OUT       (psel),
		.NEG_PIN_SEL_OUT       (nsel),
		.CMP_PIN_OUT           (pin),
		.RISE_IRQ_OUT          (rirq),
		.FALL_IRQ_OUT          (firq)
	);

	//------------------------------------------------------------------
	// Clock and hang guard
	//------------------------------------------------------------------
	initial
	begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	// A healthy run needs about 220 cycles
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 4000)
		begin
			err_count++;
			$display("timeout after %0d cycles", cycles);
			stop_test();
		end
	end

	//------------------------------------------------------------------
	// Access and compare tasks
	//------------------------------------------------------------------
	// One-cycle write strobe, taken at the following edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		sfr_addr  <= a;
		sfr_wdata <= d;
		sfr_wr    <= 1'b1;
		@(posedge ref_clk);
		sfr_wr    <= 1'b0;
	endtask

	// Read data is registered, so it is sampled just after the taking edge
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		sfr_addr <= a;
		sfr_rd   <= 1'b1;
		@(posedge ref_clk);
		sfr_rd   <= 1'b0;
		#1 d = rdata;
	endtask

	task automatic check8(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic check1(input logic got, input logic exp);
		n_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		rd(a, d);
		check8(d, exp);
	endtask

	// Waits whole cycles and steps past the edge updates
	task automatic cyc(input int k);
		repeat (k) @(posedge ref_clk);
		#1;
	endtask

	task automatic end_test(input string name);
		$display("test %s done, %0d mismatches so far", name, err_count);
	endtask

	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	//------------------------------------------------------------------
	// Main sequence
	//------------------------------------------------------------------
	initial
	begin
		rst_n = 1'b0;
		sfr_addr = 8'h00;
		sfr_wr = 1'b0;
		sfr_rd = 1'b0;
		sfr_wdata = 8'h00;
		cmp_raw = 1'b0;
		err_count = 0;
		n_checks = 0;
		repeat (20) @(posedge ref_clk);
		rst_n <= 1'b1;
		cyc(2);
		// Reset values at the ports and in the registers
		check8({6'h00, rmode}, 8'h02);
		check8(psel, 8'h00);
		check1(cmp_en, 1'b0);
		rd_chk(`CMPC_ADDR_CTRL, 8'h00);
		rd_chk(`CMPC_ADDR_MUX, 8'hff);
		rd_chk(`CMPC_ADDR_MODE, 8'h02);
		end_test("reset");
		// Hysteresis codes, positive and negative set opposite
		for (int i = 0; i < 4; i++)
		begin
			c = i[1:0];
			wr(`CMPC_ADDR_CTRL, {4'h8, c, ~c});
			rd_chk(`CMPC_ADDR_CTRL, {4'h8, c, ~c});
			check8({6'h00, phys}, {6'h00, c});
			check8({6'h00, nhys}, {6'h00, ~c});
			check1(cmp_en, 1'b1);
		end
		// Status bit ignores writes
		wr(`CMPC_ADDR_CTRL, 8'hc0);
		rd_chk(`CMPC_ADDR_CTRL, 8'h80);
		end_test("control");
		// Mode field and unused pairs
		wr(`CMPC_ADDR_MODE, 8'hff);
		rd_chk(`CMPC_ADDR_MODE, 8'h33);
		wr(`CMPC_ADDR_MODE, 8'hcc);
		rd_chk(`CMPC_ADDR_MODE, 8'h00);
		for (int i = 0; i < 4; i++)
		begin
			c = i[1:0];
			wr(`CMPC_ADDR_MODE, {6'h00, c});
			rd_chk(`CMPC_ADDR_MODE, {6'h00, c});
			check8({6'h00, rmode}, {6'h00, c});
		end
		end_test("mode");
		// Every mux code on both halves, including the no-pin codes
		for (int i = 0; i < 16; i++)
		begin
			n = i[3:0];
			p = ~n;
			wr(`CMPC_ADDR_MUX, {n, p});
			rd_chk(`CMPC_ADDR_MUX, {n, p});
			check8(nsel, n[3] ? 8'h00 : (8'h01 << n[2:0]));
			check8(psel, p[3] ? 8'h00 : (8'h01 << p[2:0]));
		end
		// Unmapped address reads zero and keeps nothing
		wr(8'h9c, 8'h5a);
		rd_chk(8'h9c, 8'h00);
		end_test("mux");
		// Edges, flags and masked requests
		wr(`CMPC_ADDR_CTRL, 8'h80);
		cyc(4);
		wr(`CMPC_ADDR_CTRL, 8'h80);
		wr(`CMPC_ADDR_MODE, 8'h20);
		@(posedge ref_clk);
		cmp_raw <= 1'b1;
		cyc(6);
		check1(pin, 1'b1);
		check1(rirq, 1'b1);
		check1(firq, 1'b0);
		rd_chk(`CMPC_ADDR_CTRL, 8'he0);
		@(posedge ref_clk);
		cmp_raw <= 1'b0;
		cyc(6);
		check1(firq, 1'b0);
		rd_chk(`CMPC_ADDR_CTRL, 8'hb0);
		wr(`CMPC_ADDR_MODE, 8'h30);
		cyc(3);
		check1(firq, 1'b1);
		wr(`CMPC_ADDR_CTRL, 8'h80);
		cyc(3);
		check1(rirq, 1'b0);
		check1(firq, 1'b0);
		rd_chk(`CMPC_ADDR_CTRL, 8'h80);
		// Clear taken at the edge that sets the flag: the set wins
		@(posedge ref_clk);
		cmp_raw <= 1'b1;
		repeat (1) @(posedge ref_clk);
		wr(`CMPC_ADDR_CTRL, 8'h80);
		cyc(3);
		rd_chk(`CMPC_ADDR_CTRL, 8'he0);
		end_test("edges");
		// Disabled: no edges, pin held low even with the input high
		wr(`CMPC_ADDR_CTRL, 8'h00);
		@(posedge ref_clk);
		cmp_raw <= 1'b0;
		repeat (5) @(posedge ref_clk);
		cmp_raw <= 1'b1;
		cyc(6);
		check1(cmp_en, 1'b0);
		check1(pin, 1'b0);
		rd_chk(`CMPC_ADDR_CTRL, 8'h00);
		end_test("disabled");
		// Reset in mid-run restores every register
		@(posedge ref_clk);
		rst_n <= 1'b0;
		repeat (3) @(posedge ref_clk);
		rst_n <= 1'b1;
		cyc(2);
		check8(nsel, 8'h00);
		rd_chk(`CMPC_ADDR_MUX, 8'hff);
		rd_chk(`CMPC_ADDR_MODE, 8'h02);
		rd_chk(`CMPC_ADDR_CTRL, 8'h00);
		end_test("reset again");
		stop_test();
	end

endmodule // tb
